// >>> src/fpoc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpoc_map.svh"
module fpoc_top import fpoc_pkg::*; (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // host index and data ports
   input  wire logic       port_data_sel_i,
   input  wire logic       port_wr_i,
   input  wire logic       port_rd_i,
   input  wire logic [7:0] port_wdata_i,
   output logic      [7:0] port_rdata_o,
   output logic            port_rvalid_o,
   // cpu fan
   output logic            cpu_fan_drive_output_o,
   output logic      [7:0] cpu_fan_dc_level_o,
   output logic            cpu_fan_period_o,
   // system fan
   output logic            system_fan_output_type_select_o
);
   // ****************************************
   // host port
   // ****************************************
   fpoc_bus_req_t  req;
   logic [6:0]     index_q;
   logic [2:0]     bank_q;
   fpoc_freq_cfg_t freq_q;
   logic [7:0]     duty_q;
   logic           sys_sel_q;
   logic           cpu_dc_q;
   logic [7:0]     rdata_q;
   logic           rvalid_q;
   logic           pwm;
   logic           period;

   // pack the host strobes
   assign req = '{data_sel: port_data_sel_i,
                  wr:       port_wr_i,
                  rd:       port_rd_i,
                  wdata:    port_wdata_i};

   // bank and index match, used by reads and writes
   function automatic logic hit(input logic [2:0] b_q,
                                input logic [6:0] i_q,
                                input logic [2:0] b,
                                input logic [6:0] i);
      hit = (b_q == b) && (i_q == i);
   endfunction : hit

   // decode of the selected location
   wire idx_wr   = req.wr && !req.data_sel;
   wire data_wr  = req.wr && req.data_sel;
   wire sel_bank = (index_q == `FPOC_IDX_BANK);
   wire sel_freq = hit(bank_q, index_q, `FPOC_BANK0, `FPOC_IDX_FREQ);
   wire sel_duty = hit(bank_q, index_q, `FPOC_BANK0, `FPOC_IDX_DUTY);
   wire sel_sys  = hit(bank_q, index_q, `FPOC_BANK0, `FPOC_IDX_SYSCFG);
   wire sel_cpu  = hit(bank_q, index_q, `FPOC_BANK0, `FPOC_IDX_CPUCFG);
   wire sel_dwr  = hit(bank_q, index_q, `FPOC_BANK2, `FPOC_IDX_DUTY_WR);

   // read selection; unmapped and reserved bits read zero
   wire [7:0] reg_mux =
      sel_bank ? {5'h00, bank_q} :
      sel_freq ? freq_q :
      (sel_duty || sel_dwr) ? duty_q :
      sel_sys  ? {7'h00, sys_sel_q} :
      sel_cpu  ? {7'h00, cpu_dc_q} :
      8'h00;
   // the address port reads back the pointer, bit 7 as zero
   wire [7:0] rd_mux = req.data_sel ? reg_mux : {1'b0, index_q};

   // index pointer and bank select
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         index_q <= 7'h00;
         bank_q  <= `FPOC_BANK_RST;
      end else begin
         if (idx_wr)
            index_q <= req.wdata[6:0];
         if (data_wr && sel_bank)
            bank_q <= req.wdata[2:0];
      end
   end

   // frequency configuration
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         freq_q <= `FPOC_FREQ_RST;
      end else if (data_wr && sel_freq) begin
         freq_q <= req.wdata;
      end
   end

   // duty value; the bank 0 alias ignores writes
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         duty_q <= `FPOC_DUTY_RST;
      end else if (data_wr && sel_dwr) begin
         duty_q <= req.wdata;
      end
   end

   // output mode bits
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sys_sel_q <= `FPOC_SYSCFG_RST;
         cpu_dc_q  <= `FPOC_CPUCFG_RST;
      end else begin
         if (data_wr && sel_sys)
            sys_sel_q <= req.wdata[`FPOC_BIT_MODE];
         if (data_wr && sel_cpu)
            cpu_dc_q <= req.wdata[`FPOC_BIT_MODE];
      end
   end

   // read data captured one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
         if (req.rd)
            rdata_q <= rd_mux;
      end
   end

   assign port_rdata_o  = rdata_q;
   assign port_rvalid_o = rvalid_q;

   // ****************************************
   // cpu fan waveform
   // ****************************************
   // the core keeps counting in dc mode so a return to pwm is glitch free
   fpoc_pwm_core fpoc_pwm_core_inst (
      .clk_i    (clk_i),
      .srst_i   (srst_i),
      .cfg_i    (freq_q),
      .duty_i   (duty_q),
      .run_i    (!cpu_dc_q),
      .pwm_o    (pwm),
      .period_o (period)
   );

   assign cpu_fan_drive_output_o = pwm;
   assign cpu_fan_period_o       = period && !cpu_dc_q;
   // dc level feeds an external converter, not modelled here
   assign cpu_fan_dc_level_o     = duty_q;

   assign system_fan_output_type_select_o = sys_sel_q;

   // ****************************************
   // checks
   // ****************************************
   // bank 0 alias is read only
   property p_duty_ro;
      @(posedge clk_i) disable iff (srst_i)
         (data_wr && sel_duty) |=> $stable(duty_q);
   endproperty
   a_duty_ro: assert property (p_duty_ro) else $error("duty changed by bank 0 write");

   property p_duty_wr;
      @(posedge clk_i) disable iff (srst_i)
         (data_wr && sel_dwr) |=> (duty_q == $past(req.wdata));
   endproperty
   a_duty_wr: assert property (p_duty_wr) else $error("bank 2 duty write lost");

   property p_dc_low;
      @(posedge clk_i) disable iff (srst_i)
         cpu_dc_q [*2] |-> !cpu_fan_drive_output_o && !cpu_fan_period_o;
   endproperty
   a_dc_low: assert property (p_dc_low) else $error("pwm active in dc mode");

   property p_sys_sel;
      @(posedge clk_i) disable iff (srst_i)
         (data_wr && sel_sys) |=>
            (system_fan_output_type_select_o == $past(req.wdata[0]));
   endproperty
   a_sys_sel: assert property (p_sys_sel) else $error("system fan type not updated");

   property p_sys_rst;
      @(posedge clk_i) $fell(srst_i) |-> system_fan_output_type_select_o;
   endproperty
   a_sys_rst: assert property (p_sys_rst) else $error("system fan type not dc at reset");

   property p_freq_wr;
      @(posedge clk_i) disable iff (srst_i)
         (data_wr && sel_freq) |=> (freq_q.prescale == $past(req.wdata[6:0]))
                                   && (freq_q.clk_sel == $past(req.wdata[7]));
   endproperty
   a_freq_wr: assert property (p_freq_wr) else $error("frequency write lost");

   // duty readback at bank 0 index 3
   property p_duty_rd;
      @(posedge clk_i) disable iff (srst_i)
         (req.rd && req.data_sel && sel_duty && !data_wr) |=>
            port_rvalid_o && (port_rdata_o == duty_q);
   endproperty
   a_duty_rd: assert property (p_duty_rd) else $error("duty readback wrong");
endmodule : fpoc_top
`default_nettype wire

// >>> src/fpoc_map.svh
// Behaviour
// - frequency register bit 7 picks one of two PWM source clocks.
// - frequency register bits 6-0 hold the prescale divider value.
// - source 0 gives 93.9 kHz divided by prescale plus one.
// - source 1 gives 1008 Hz divided by mapped low four prescale bits.
// - duty equals value over 255; FFh full on, zero always off.
// - duty register read-only in bank 0 cpu_fan_duty_value, written bank 2 index 09.
// - frequency setting acts only while the CPU fan output is in PWM mode.
// - system fan config bit 0: 0 PWM, 1 DC; resets to DC.
`ifndef FPOC_MAP_SVH
`define FPOC_MAP_SVH
// ****************************************
// register indexes and banks
// ****************************************
`define FPOC_IDX_FREQ    7'h02
`define FPOC_IDX_DUTY    7'h03
`define FPOC_IDX_SYSCFG  7'h04
`define FPOC_IDX_CPUCFG  7'h4d
`define FPOC_IDX_BANK    7'h4e
`define FPOC_IDX_DUTY_WR 7'h09
`define FPOC_BANK0       3'h0
`define FPOC_BANK2       3'h2
// ****************************************
// field positions and reset values
// ****************************************
`define FPOC_BIT_MODE    0
`define FPOC_FREQ_RST    8'h04
`define FPOC_DUTY_RST    8'hff
`define FPOC_SYSCFG_RST  1'h1
`define FPOC_CPUCFG_RST  1'h0
`define FPOC_BANK_RST    3'h0
// ****************************************
// timing
// ****************************************
`define FPOC_CLK_HZ      200000000
`define FPOC_SRC0_HZ     93900
`define FPOC_SRC1_HZ     1008
`define FPOC_PWM_STEPS   255
`define FPOC_SRC0_TICKS  (`FPOC_CLK_HZ / (`FPOC_SRC0_HZ * `FPOC_PWM_STEPS))
`define FPOC_SRC1_TICKS  (`FPOC_CLK_HZ / (`FPOC_SRC1_HZ * `FPOC_PWM_STEPS))
`define FPOC_STEP_LAST   8'hfe
// mapped divisors of source 1 codes 8 and 9; higher codes double from 9
`define FPOC_DIV_MAP8    11'h00c
`define FPOC_DIV_MAP9    11'h010
`endif

// >>> src/fpoc_pkg.sv
package fpoc_pkg;
   // frequency register layout
   typedef struct packed {
      logic       clk_sel;
      logic [6:0] prescale;
   } fpoc_freq_cfg_t;
   // host port request
   typedef struct packed {
      logic       data_sel;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } fpoc_bus_req_t;
endpackage : fpoc_pkg

// >>> src/fpoc_pwm_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpoc_map.svh"
module fpoc_pwm_core import fpoc_pkg::*; (
   // clock and reset
   input  wire logic           clk_i,
   input  wire logic           srst_i,
   // setting
   input  wire fpoc_freq_cfg_t cfg_i,
   input  wire logic [7:0]     duty_i,
   input  wire logic           run_i,
   // waveform
   output logic                pwm_o,
   output logic                period_o
);
   logic [9:0]  src0_q, src1_q;
   logic [10:0] pre_q;
   logic [7:0]  cnt_q;
   logic        pwm_q, period_q;
   // source ticks, truncated so the step rate never falls below nominal
   wire src0_tick = (src0_q == 10'(`FPOC_SRC0_TICKS - 1));
   wire src1_tick = (src1_q == 10'(`FPOC_SRC1_TICKS - 1));
   wire src_tick = cfg_i.clk_sel ? src1_tick : src0_tick;
   function automatic logic [10:0] map_div(input logic [3:0] c);
      if (!c[3])
         map_div = 11'({1'b0, c} + 5'h01);
      else if (c[2:0] == 3'h0)
         map_div = `FPOC_DIV_MAP8;
      else
         map_div = `FPOC_DIV_MAP9 << (c[2:0] - 3'h1);
   endfunction : map_div
   wire [10:0] div = cfg_i.clk_sel ? map_div(cfg_i.prescale[3:0])
                                   : 11'({4'h0, cfg_i.prescale} + 11'h001);
   wire step = src_tick && (pre_q >= div - 11'h001);
   wire wrap = step && (cnt_q == `FPOC_STEP_LAST);
   // counters
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         src0_q   <= 10'h000;
         src1_q   <= 10'h000;
         pre_q    <= 11'h000;
         cnt_q    <= 8'h00;
         pwm_q    <= 1'b0;
         period_q <= 1'b0;
      end else begin
         src0_q   <= src0_tick ? 10'h000 : src0_q + 10'h001;
         src1_q   <= src1_tick ? 10'h000 : src1_q + 10'h001;
         if (src_tick)
            pre_q <= step ? 11'h000 : pre_q + 11'h001;
         if (step)
            cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
         pwm_q    <= run_i && (cnt_q < duty_i);
         period_q <= wrap;
      end
   end
   assign pwm_o    = pwm_q;
   assign period_o = period_q;
   property p_cnt_bound;
      @(posedge clk_i) disable iff (srst_i) cnt_q <= `FPOC_STEP_LAST;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("step count past 254");
   property p_full;
      @(posedge clk_i) disable iff (srst_i) (run_i && duty_i == 8'hff) |=> pwm_q;
   endproperty
   a_full: assert property (p_full) else $error("duty ff not full on");
   property p_zero;
      @(posedge clk_i) disable iff (srst_i) (duty_i == 8'h00) |=> !pwm_q;
   endproperty
   a_zero: assert property (p_zero) else $error("duty zero not off");
   property p_src0;
      @(posedge clk_i) disable iff (srst_i) src0_tick |=> !src0_tick [*7] ##1 src0_tick;
   endproperty
   a_src0: assert property (p_src0) else $error("source 0 tick spacing wrong");
   property p_step_src;
      @(posedge clk_i) disable iff (srst_i) step |-> (cfg_i.clk_sel ? src1_tick : src0_tick);
   endproperty
   a_step_src: assert property (p_step_src) else $error("step off source tick");
endmodule : fpoc_pwm_core
`default_nettype wire

// >>> dv/fpoc_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// fan that averages its drive
// ****
module fpoc_fan_model (
   // drive from the block
   input  wire logic        clk_i,
   input  wire logic        pwm_i,
   input  wire logic        period_i,
   // what the fan saw
   output logic      [15:0] hi_o,
   output logic      [15:0] len_o,
   output logic      [15:0] nper_o
);
   // a fan has no reset pin, so start from zero
   logic [15:0] hi_q   = 16'h0000;
   logic [15:0] len_q  = 16'h0000;
   logic [15:0] nper_q = 16'h0000;
   assign nper_o = nper_q;
   // integrate drive between period marks
   always @(posedge clk_i) begin
      if (period_i === 1'b1) begin
         hi_o   <= hi_q + 16'(pwm_i);
         len_o  <= len_q + 16'h0001;
         nper_q <= nper_q + 16'h0001;
         hi_q   <= '0;
         len_q  <= '0;
      end else begin
         hi_q  <= hi_q + 16'(pwm_i);
         len_q <= len_q + 16'h0001;
      end
   end
endmodule : fpoc_fan_model
`default_nettype wire

// >>> dv/fpoc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// register and waveform bench
// ****
module fpoc_top_tb;
   logic        clk_i;
   logic        srst_i;
   logic        sel;
   logic        wr;
   logic        rd;
   logic [7:0]  wd;
   logic [7:0]  rdata;
   logic        rvalid;
   logic        pwm;
   logic        per;
   logic        styp;
   logic [7:0]  dcl;
   logic [15:0] hi;
   logic [15:0] len;
   logic [15:0] nper;
   logic [7:0]  cf [4];
   int          lo [4];
   int          fail_count;
   int          check_count;
   int          t;
   int          h;
   fpoc_top fpoc_top_inst (.clk_i(clk_i), .srst_i(srst_i), .port_data_sel_i(sel),
      .port_wr_i(wr), .port_rd_i(rd), .port_wdata_i(wd), .port_rdata_o(rdata),
      .port_rvalid_o(rvalid), .cpu_fan_drive_output_o(pwm), .cpu_fan_dc_level_o(dcl),
      .cpu_fan_period_o(per), .system_fan_output_type_select_o(styp));
   fpoc_fan_model fpoc_fan_model_inst (.clk_i(clk_i), .pwm_i(pwm), .period_i(per),
      .hi_o(hi), .len_o(len), .nper_o(nper));
   // 200 mhz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   // span lets rate checks accept a window; unknown never passes
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int span = 0);
      check_count++;
      if (!((got >= exp) === 1'b1 && (got <= exp + span) === 1'b1)) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic pw(input logic s, input logic [7:0] d);
      @(negedge clk_i);
      sel = s;
      wd  = d;
      wr  = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
   endtask : pw
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      pw(1'b0, a);
      pw(1'b1, d);
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      int n;
      pw(1'b0, a);
      @(negedge clk_i);
      sel = 1'b1;
      rd  = 1'b1;
      @(negedge clk_i);
      rd = 1'b0;
      n  = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clk_i);
         n++;
      end
      chk(16'(n), 16'h0000);
      chk({8'h00, rdata}, {8'h00, e});
   endtask : rreg
   // duty is only writable through bank 2
   task automatic duty(input logic [7:0] d);
      wreg(8'h4e, 8'h02);
      wreg(8'h09, d);
      wreg(8'h4e, 8'h00);
   endtask : duty
   task automatic wait_per(input int k);
      logic [15:0] tg;
      tg = nper + 16'(k);
      t  = 0;
      while (nper < tg && t < 30000) begin
         @(negedge clk_i);
         t++;
      end
      if (t >= 30000) begin
         fail_count++;
         stop_test();
      end
   endtask : wait_per
   task automatic rst;
      srst_i = 1'b1;
      repeat (5) @(negedge clk_i);
      srst_i = 1'b0;
   endtask : rst
   // main sequence
   initial begin
      {sel, wr, rd, wd} = '0;
      fail_count  = 0;
      check_count = 0;
      // code 88h exercises the first mapped divisor, 12
      cf = '{8'h7f, 8'h80, 8'h89, 8'h88};
      lo = '{964, 678, 12348, 9236};
      rst();
      rreg(8'h02, 8'h04);
      rreg(8'h03, 8'hff);
      rreg(8'h04, 8'h01);
      chk(16'(styp), 16'h0001);
      wreg(8'h04, 8'hff);
      rreg(8'h04, 8'h01);
      wreg(8'h04, 8'h00);
      chk(16'(styp), 16'h0000);
      $display("test reset_and_mode done");
      wreg(8'h03, 8'h00);
      rreg(8'h03, 8'hff);
      duty(8'h80);
      rreg(8'h03, 8'h80);
      chk({8'h00, dcl}, 16'h0080);
      $display("test duty_access done");
      wreg(8'h02, 8'h00);
      wait_per(2);
      chk(len, 16'd2040);
      chk(hi, 16'd1024);
      duty(8'hff);
      wait_per(2);
      chk(hi, 16'd2040);
      duty(8'h00);
      wait_per(2);
      chk(hi, 16'h0000);
      $display("test duty_levels done");
      // dc mode: no waveform and no period marks
      duty(8'h80);
      wreg(8'h4d, 8'h01);
      t = 0;
      h = int'(nper);
      repeat (3000) begin
         @(negedge clk_i);
         t += (pwm !== 1'b0);
      end
      chk(16'(t), 16'h0000);
      chk(nper, 16'(h));
      $display("test dc_mode done");
      // first step length after a fresh reset, duty 1
      for (int i = 0; i < 4; i++) begin
         rst();
         wreg(8'h02, cf[i]);
         wreg(8'h4e, 8'h02);
         wreg(8'h09, 8'h01);
         t = 12;
         while (pwm === 1'b1 && t < 20000) begin
            @(negedge clk_i);
            t++;
         end
         chk(16'(t), 16'(lo[i]), (i == 0) ? 120 : 1000);
      end
      $display("test step_rate done");
      stop_test();
   end
endmodule : fpoc_top_tb
`default_nettype wire
